// File: design/apmc_pkg.sv
/*
 * Constants, types and state encodings for the converter power-mode controller.
 * Assumes a 100 MHz system clock; all timing counts derive from that rate.
 */
package apmc_pkg;

	// ----------------------------------------------------------------
	// Control word layout
	// ----------------------------------------------------------------
	localparam int          CTRL_BITS       = 8;
	localparam int          PM_HI_POS       = 1;
	localparam int          PM_LO_POS       = 0;
	localparam int          REF_OFF_POS     = 2;
	localparam int          EDGE_LOAD_LAST  = 8;
	localparam int          EDGE_SAMPLE     = 2;
	localparam int          EDGE_LAST       = 16;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;

	// ----------------------------------------------------------------
	// Power modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		APMC_MODE_NORMAL   = 2'b00,
		APMC_MODE_SHUTDOWN = 2'b01,
		APMC_MODE_AUTO_SD  = 2'b10,
		APMC_MODE_AUTO_SB  = 2'b11
	} apmc_mode_t;

	// Power state, Gray along off -> waking -> on.
	typedef enum logic [1:0] {
		APMC_PWR_OFF    = 2'b00,
		APMC_PWR_WAKING = 2'b01,
		APMC_PWR_ON     = 2'b11,
		APMC_PWR_SPARE  = 2'b10
	} apmc_pwr_t;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ      = 100;
	localparam int WAKE_SB_NS       = 1000;
	localparam int WAKE_SD_NS       = 5000;
	localparam int WAKE_SB_CYCLES   = (WAKE_SB_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int WAKE_SD_CYCLES   = (WAKE_SD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int WAKE_CNT_BITS    = 10;

	// ----------------------------------------------------------------
	// Events carried from the link domain as toggles
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wake_tgl;
		logic       sleep_tgl;
		logic       update_tgl;
		logic [7:0] ctrl;
	} apmc_link_evt_t;

endpackage

// File: design/apmc_sync.sv
/*
 * Two-flop level synchroniser, one per bit.
 * Assumes the input is quasi-static relative to the destination clock.
 */
`timescale 1ns/1ps
module apmc_sync
	import apmc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			meta_q <= '0;
			q_out  <= '0;
		end
		else
		begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule // apmc_sync

// File: design/apmc_link.sv
/*
 * Serial-clock side: counts edges of one transfer, shifts in the control
 * word and raises toggles for wake, sleep and control update.
 * Assumes sclk stands still or is ignored while chip select is high, and that
 * cs_n is asynchronous to sclk; its rising edge resets the count.
 */
`timescale 1ns/1ps
module apmc_link
	import apmc_pkg::*;
(
	input  wire logic     sclk_in,
	input  wire logic     cs_n_in,
	input  wire logic     sdi_in,
	output apmc_link_evt_t evt_out,
	output logic           sample_out
);
	logic [4:0] rise_q;
	logic [7:0] shift_q;
	logic       fall_seen_q;
	// The link has no reset of its own; power-up values seed the toggles.
	logic       wake_q  = 1'b0;
	logic       sleep_q = 1'b0;
	logic       upd_q   = 1'b0;
	logic [7:0] ctrl_q  = CTRL_RESET;

	// Edge counting restarts whenever chip select is high.
	always_ff @(posedge sclk_in or posedge cs_n_in)
	begin
		if (cs_n_in)
		begin
			rise_q  <= 5'h00;
			shift_q <= 8'h00;
		end
		else if (rise_q != 5'(EDGE_LAST))
		begin
			rise_q <= rise_q + 5'h01;
			if (rise_q < 5'(EDGE_LOAD_LAST))
				shift_q <= {shift_q[6:0], sdi_in};
		end
	end

	// Word update and sleep on the sixteenth rising edge.
	always_ff @(posedge sclk_in)
	begin
		if (!cs_n_in && rise_q == 5'(EDGE_LAST - 1))
		begin
			ctrl_q  <= shift_q;
			upd_q   <= ~upd_q;
			sleep_q <= ~sleep_q;
		end
	end

	// First falling edge after chip select falls starts the wake-up.
	always_ff @(negedge sclk_in or posedge cs_n_in)
	begin
		if (cs_n_in)
			fall_seen_q <= 1'b0;
		else if (!fall_seen_q)
		begin
			fall_seen_q <= 1'b1;
			wake_q      <= ~wake_q;
		end
	end

	// Hold occurs on the second rising edge after chip select falls.
	assign sample_out = (rise_q == 5'(EDGE_SAMPLE));

	assign evt_out = '{wake_tgl: wake_q, sleep_tgl: sleep_q, update_tgl: upd_q, ctrl: ctrl_q};
endmodule // apmc_link

// File: design/apmc_top.sv
/*
 * Power-mode controller of a serially controlled converter.
 * Assumes the serial clock is the link clock and chip select frames it.
 */
// Function
// - Auto modes drop to low power on sixteenth rising clock after select.
// - Auto modes start waking on first falling clock after select falls.
// - Full shutdown exits by writing any other mode; only normal mode powers up at once.
// - New mode takes effect on the sixteenth rising clock edge.
// - Mode changes two system clocks after the control word update lands.
// - Wake from standby with the reference on takes about 1 us; with the reference-disable bit set it takes about 5 us.
// - Reset comes up fully powered in normal mode.
// - Any shutdown needs about 5 us to power up fully.
// - Standby wake is short enough for a valid result in one transfer.
// - First eight clock cycles of data in load the control word.
// - Input sampled on second rising clock edge after select falls.
// - Host gives sixteen clocks per transfer.
// - Normal mode accepts a new conversion at once after select rises.
// - Full shutdown powers all off, keeps control word, reference off.
// - Shutdown changed to auto shutdown stays off until next conversion.
// - Auto standby keeps the reference on after each conversion while the reference-disable bit is low.
// - Control word is overwritten only by transfers that reach the sixteenth rising clock.
`timescale 1ns/1ps
module apmc_top
	import apmc_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic       sdi_in,
	output logic            core_pwr_on_out,
	output logic            ref_pwr_on_out,
	output logic            ready_out,
	output logic [1:0]      mode_out,
	output logic            sample_out
);
	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	apmc_link_evt_t evt;
	logic           sample_raw;

	apmc_link u_link (
		.sclk_in    (sclk_in),
		.cs_n_in    (cs_n_in),
		.sdi_in     (sdi_in),
		.evt_out    (evt),
		.sample_out (sample_raw)
	);

	// ----------------------------------------------------------------
	// Crossing; the control word changes on the same sclk edge as its update toggle.
	// ----------------------------------------------------------------
	logic [11:0] sync_d;
	logic [11:0] sync_q;

	assign sync_d = {evt.wake_tgl, evt.sleep_tgl, evt.update_tgl, sample_raw, evt.ctrl};

	apmc_sync #(.WIDTH(12)) u_sync (
		.clk_in  (sys_clk_in),
		.rstn_in (rstn_in),
		.d_in    (sync_d),
		.q_out   (sync_q)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		apmc_mode_t             mode;
		apmc_pwr_t              pwr;
		logic                   ref_on;
		logic                   ready;
		logic [WAKE_CNT_BITS-1:0] wait_cnt;
		logic                   wake_t;
		logic                   sleep_t;
		logic                   upd_t;
		logic                   upd_p;
		logic                   sample;
		logic                   from_sd;
	} apmc_state_t;

	apmc_state_t s_q;
	apmc_state_t s_d;

	function automatic logic [WAKE_CNT_BITS-1:0] wake_len(input logic deep);
		wake_len = deep ? WAKE_CNT_BITS'(WAKE_SD_CYCLES) : WAKE_CNT_BITS'(WAKE_SB_CYCLES);
	endfunction

	logic       wake_ev;
	logic       sleep_ev;
	logic       upd_ev;
	apmc_mode_t new_mode;
	logic       ref_dis;

	assign wake_ev  = sync_q[11] ^ s_q.wake_t;
	assign sleep_ev = sync_q[10] ^ s_q.sleep_t;
	assign upd_ev   = sync_q[9]  ^ s_q.upd_t;
	assign new_mode = apmc_mode_t'({sync_q[PM_HI_POS], sync_q[PM_LO_POS]});
	assign ref_dis  = sync_q[REF_OFF_POS];

	always_comb
	begin
		s_d         = s_q;
		s_d.wake_t  = sync_q[11];
		s_d.sleep_t = sync_q[10];
		s_d.upd_t   = sync_q[9];
		s_d.sample  = sync_q[8];
		// The word bits may land one cycle after their toggle, so act a cycle late.
		s_d.upd_p   = upd_ev;

		// Wake-up count runs in the system domain.
		if (s_q.pwr == APMC_PWR_WAKING)
		begin
			if (s_q.wait_cnt <= 1)
			begin
				s_d.pwr   = APMC_PWR_ON;
				s_d.ready = 1'b1;
			end
			else
				s_d.wait_cnt = s_q.wait_cnt - 1'b1;
		end

		// Auto modes wake on the first falling clock of a transfer.
		if (wake_ev && s_q.pwr == APMC_PWR_OFF &&
			(s_q.mode == APMC_MODE_AUTO_SD || s_q.mode == APMC_MODE_AUTO_SB))
		begin
			s_d.pwr      = APMC_PWR_WAKING;
			s_d.ready    = 1'b0;
			s_d.ref_on   = 1'b1;
			// Short standby wake gives a result in the same transfer.
			s_d.wait_cnt = wake_len(!s_q.ref_on);
		end

		// Control update and auto sleep on the sixteenth rising edge.
		if (s_q.upd_p)
		begin
			s_d.mode = new_mode;
			case (new_mode)
				APMC_MODE_NORMAL:
				begin
					// A powered part stays ready, with no recovery between frames.
					if (s_q.pwr == APMC_PWR_OFF)
					begin
						// Any powered-off state, shutdown or auto, wakes at once in normal mode.
						s_d.pwr      = APMC_PWR_WAKING;
						s_d.ref_on   = 1'b1;
						s_d.wait_cnt = wake_len(!s_q.ref_on || ref_dis);
					end
				end
				APMC_MODE_SHUTDOWN:
				begin
					// Everything off, word kept.
					s_d.pwr    = APMC_PWR_OFF;
					s_d.ref_on = 1'b0;
					s_d.ready  = 1'b0;
				end
				APMC_MODE_AUTO_SD:
				begin
					s_d.pwr    = APMC_PWR_OFF;
					s_d.ref_on = 1'b0;
					s_d.ready  = 1'b0;
				end
				APMC_MODE_AUTO_SB:
				begin
					s_d.pwr    = APMC_PWR_OFF;
					s_d.ref_on = !ref_dis;
					s_d.ready  = 1'b0;
				end
				default:
				begin
					s_d.pwr = s_q.pwr;
				end
			endcase
		end
		s_d.from_sd = sleep_ev;
	end

	// Reset enters normal mode fully powered.
	always_ff @(posedge sys_clk_in)
	begin
		if (!rstn_in)
		begin
			s_q          <= '0;
			s_q.mode     <= APMC_MODE_NORMAL;
			s_q.pwr      <= APMC_PWR_ON;
			s_q.ref_on   <= 1'b1;
			s_q.ready    <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign core_pwr_on_out = s_q.pwr != APMC_PWR_OFF;
	assign ref_pwr_on_out  = s_q.ref_on;
	assign ready_out       = s_q.ready;
	assign mode_out        = s_q.mode;
	assign sample_out      = s_q.sample;
endmodule // apmc_top

// File: tb/apmc_chk_chk.sv
/* Port assertions for the power-mode controller.
   Assumes the host keeps the reference-disable bit low. */
`timescale 1ns/1ps
module apmc_chk
	import apmc_pkg::*;
(
	input wire logic       sys_clk_in,
	input wire logic       rstn_in,
	input wire logic       sclk_in,
	input wire logic       cs_n_in,
	input wire logic       sdi_in,
	input wire logic       core_pwr_on_out,
	input wire logic       ref_pwr_on_out,
	input wire logic       ready_out,
	input wire logic [1:0] mode_out,
	input wire logic       sample_out
);
	logic [9:0] wcnt_q;
	// Counts the cycles spent powered but not yet ready.
	always_ff @(posedge sys_clk_in)
		wcnt_q <= (core_pwr_on_out && !ready_out) ? wcnt_q + 10'h001 : 10'h000;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	a_reset_full_on: assert property ($rose(rstn_in) |->
		mode_out == 2'h0 && core_pwr_on_out && ready_out) else $error("reset state");
	a_shutdown_all_off: assert property ((mode_out == 2'h1)[*3] |->
		!core_pwr_on_out && !ref_pwr_on_out && !ready_out) else $error("shutdown");
	a_normal_stays_on: assert property ((mode_out == 2'h0)[*3] |->
		core_pwr_on_out && ref_pwr_on_out) else $error("normal power");
	a_auto_idle_off: assert property ((mode_out[1] && cs_n_in)[*8] |->
		!core_pwr_on_out && !ready_out) else $error("auto idle");
	a_wake_on_fall: assert property (mode_out[1] && !cs_n_in && $fell(sclk_in)
		|-> ##[1:6] core_pwr_on_out) else $error("wake late");
	a_sb_wake_time: assert property ($rose(ready_out) && mode_out == 2'h3
		|-> wcnt_q inside {[10'h063:10'h066]}) else $error("standby wake");
	a_sd_wake_time: assert property ($rose(ready_out) && mode_out == 2'h2
		|-> wcnt_q inside {[10'h1f3:10'h1f6]}) else $error("shutdown wake");
	a_ready_needs_core: assert property (ready_out |-> core_pwr_on_out)
		else $error("ready unpowered");
	a_standby_ref_on: assert property ((mode_out == 2'h3)[*3] |->
		ref_pwr_on_out) else $error("standby ref");
	a_sample_in_frame: assert property (sample_out |-> !cs_n_in)
		else $error("sample outside frame");
	cover property ($rose(ready_out) && mode_out == 2'h3);
	cover property ($rose(ready_out) && mode_out == 2'h2);
	cover property ($fell(core_pwr_on_out));
endmodule // apmc_chk

bind apmc_top apmc_chk u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sclk_in(sclk_in),
	.cs_n_in(cs_n_in), .sdi_in(sdi_in), .core_pwr_on_out(core_pwr_on_out),
	.ref_pwr_on_out(ref_pwr_on_out), .ready_out(ready_out), .mode_out(mode_out),
	.sample_out(sample_out));

// File: tb/apmc_host.sv
/* Host serial master model framing transfers with chip select.
   Assumes the device takes data on rising clock edges; clock idles high. */
`timescale 1ns/1ps
module apmc_host
(
	output logic sclk_out,
	output logic cs_n_out,
	output logic sdi_out
);
	int half = 6;
	initial
	begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		sdi_out  = 1'b0;
	end
	task automatic xfer(input logic [7:0] ctrl, input int gap, input int rises);
		logic [15:0] w;
		w = {ctrl, ~ctrl};
		cs_n_out = 1'b0;
		#20;
		for (int i = 0; i < rises; i++)
		begin
			sclk_out = 1'b0;
			sdi_out  = w[15 - i];
			#(half);
			if (i == 0)
				#(gap);
			sclk_out = 1'b1;
			#(half);
		end
		#(half);
		cs_n_out = 1'b1;
		// Released data line shows the inverse so a stale bit is never mistaken.
		sdi_out  = ~sdi_out;
	endtask
endmodule // apmc_host

// File: tb/tb_top.sv
/* Self-checking bench for the power-mode controller.
   Assumes the host model drives the serial side from its own timing. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       sclk, cs_n, sdi, core, refp, rdy, smp;
	logic [1:0] mode;
	int         n_fail = 0;
	int         comparisons = 0;
	int         cyc = 0;
	apmc_top u_dut (.sys_clk_in(sys_clk), .rstn_in(rstn), .sclk_in(sclk), .cs_n_in(cs_n),
		.sdi_in(sdi), .core_pwr_on_out(core), .ref_pwr_on_out(refp), .ready_out(rdy),
		.mode_out(mode), .sample_out(smp));
	apmc_host u_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	task report_and_stop;
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task wc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task x(input logic [7:0] c, input int r);
		u_host.xfer(c, 0, r);
		wc(10);
	endtask
	task chk(input logic [1:0] m, input logic c, input logic y);
		`CHK("mode", m, mode)
		`CHK("core", c, core)
		`CHK("ready", y, rdy)
	endtask
	task t_normal;
		x(8'h00, 16);
		x(8'h00, 16);
		x(8'h01, 8);
		chk(2'h0, 1'b1, 1'b1);
	endtask
	task t_shut;
		x(8'h01, 16);
		chk(2'h1, 1'b0, 1'b0);
		`CHK("ref", 1'b0, refp)
		x(8'h00, 8);
		chk(2'h1, 1'b0, 1'b0);
		x(8'h02, 16);
		chk(2'h2, 1'b0, 1'b0);
	endtask
	task t_autosd;
		fork
			u_host.xfer(8'h02, 5300, 16);
			begin
				#2000 chk(2'h2, 1'b1, 1'b0);
				#3300 chk(2'h2, 1'b1, 1'b1);
			end
		join
		wc(10);
		chk(2'h2, 1'b0, 1'b0);
	endtask
	task t_autosb;
		x(8'h03, 16);
		chk(2'h3, 1'b0, 1'b0);
		`CHK("ref", 1'b1, refp)
		fork
			u_host.xfer(8'h03, 1500, 16);
			begin
				#600 chk(2'h3, 1'b1, 1'b0);
				#700 chk(2'h3, 1'b1, 1'b1);
			end
		join
		wc(10);
		chk(2'h3, 1'b0, 1'b0);
	endtask
	task t_exit;
		x(8'h02, 16);
		x(8'h00, 16);
		wc(600);
		chk(2'h0, 1'b1, 1'b1);
		x(8'h01, 16);
		x(8'h00, 16);
		chk(2'h0, 1'b1, 1'b0);
		wc(500);
		chk(2'h0, 1'b1, 1'b1);
	endtask
	task t_sample;
		u_host.half = 40;
		fork
			u_host.xfer(8'h00, 0, 16);
			begin
				#100 `CHK("sample", 1'b0, smp)
				#100 `CHK("sample", 1'b1, smp)
			end
		join
		u_host.half = 6;
	endtask
	initial
	begin
		wc(20);
		rstn = 1'b1;
		wc(2);
		chk(2'h0, 1'b1, 1'b1);
		t_normal();
		t_shut();
		t_autosd();
		t_autosb();
		t_exit();
		t_sample();
		report_and_stop();
	end
endmodule // tb_top
